// ===== src/ess_top.sv
// Simulation side of the experiment start synchronisation handshake
`timescale 1ns/100ps
`default_nettype none
module ess_top
   import ess_pkg::*;
#(
   parameter int CLK_W = ESS_CLK_W
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Status lines
   input wire logic PARTNER_SYNC,
   output logic LOCAL_SYNC,
   // Operator controls, one-cycle pulses
   input wire logic SETUP_DONE,
   input wire logic MANUAL_ABORT,
   input wire logic MANUAL_CYCLE,
   input wire logic USER_START,
   // Experiment status
   output logic LOG_ACTIVE,
   output logic LOG_FLUSH,
   output logic LOG_DISCARD,
   output logic CLK_RUNNING,
   output logic [CLK_W-1:0] EXP_TIME,
   output logic [CLK_W-1:0] END_TIME,
   output logic [6:0] STATE
);
   ess_sync_if psync ();
   ess_state_t state_r;
   ess_state_t state_nxt;
   logic [CLK_W-1:0] time_r;
   logic [CLK_W-1:0] end_r;
   logic flush_r;
   logic discard_r;
   logic active;

   ess_line_sync u_sync (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .async_in(PARTNER_SYNC),
      .sync(psync)
   );

   assign active = (state_r == ESS_READY) || (state_r == ESS_RUN);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ESS_INIT:
         begin
            if (psync.level)
               state_nxt = ESS_ERROR;
            else if (SETUP_DONE)
               state_nxt = ESS_READY;
         end
         ESS_READY:
         begin
            if (MANUAL_CYCLE)
               state_nxt = ESS_IDLE;
            else if (psync.rise)
               state_nxt = ESS_RUN;
         end
         ESS_RUN:
         begin
            if (MANUAL_ABORT || MANUAL_CYCLE)
               state_nxt = ESS_ABORT;
            else if (psync.fall)
               state_nxt = ESS_HALT_ACK;
         end
         ESS_ABORT: state_nxt = ESS_IDLE;
         ESS_HALT_ACK: state_nxt = ESS_IDLE;
         ESS_ERROR: state_nxt = ESS_IDLE;
         ESS_IDLE:
         begin
            if (USER_START)
               state_nxt = ESS_INIT;
         end
         default: state_nxt = ESS_INIT;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         state_r <= ESS_INIT;
      else
         state_r <= state_nxt;
   end

   // Experiment clock
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         time_r <= CLK_W'(ESS_CLK_RESET);
      else if (state_r == ESS_INIT)
         time_r <= CLK_W'(ESS_CLK_RESET);
      else if (state_r == ESS_RUN)
         time_r <= time_r + CLK_W'(ESS_CLK_INC);
   end

   // End timestamp capture on halt acknowledge
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         end_r <= CLK_W'(ESS_CLK_RESET);
      else if (state_r == ESS_INIT)
         end_r <= CLK_W'(ESS_CLK_RESET);
      else if (state_r == ESS_RUN && state_nxt == ESS_HALT_ACK)
         end_r <= time_r + CLK_W'(ESS_CLK_INC);
   end

   // Log flush and discard pulses
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flush_r <= 1'b0;
         discard_r <= 1'b0;
      end
      else
      begin
         flush_r <= (state_nxt == ESS_HALT_ACK);
         discard_r <= (state_nxt == ESS_ABORT);
      end
   end

   assign LOCAL_SYNC = active;
   assign LOG_ACTIVE = (state_r == ESS_RUN);
   assign CLK_RUNNING = (state_r == ESS_RUN);
   assign LOG_FLUSH = flush_r;
   assign LOG_DISCARD = discard_r;
   assign EXP_TIME = time_r;
   assign END_TIME = end_r;
   assign STATE = state_r;

   chk_init_line_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_INIT) |-> (!LOCAL_SYNC && !CLK_RUNNING))
      else $error("Line or clock active in initialize");

   chk_init_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_INIT) |=> (EXP_TIME == '0))
      else $error("Clock not cleared in initialize");

   chk_ready_raise: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_INIT && SETUP_DONE && !psync.level)
      |=> (LOCAL_SYNC && !LOG_ACTIVE && !CLK_RUNNING))
      else $error("Ready entry wrong");

   sequence s_ready_rise;
      (state_r == ESS_READY && !MANUAL_CYCLE) ##0 psync.rise;
   endsequence
   chk_run_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_ready_rise |=> (LOG_ACTIVE && CLK_RUNNING) ##1 (EXP_TIME == $past(EXP_TIME) + 1))
      else $error("Run did not start clocks");

   sequence s_abort_req;
      (state_r == ESS_RUN) ##0 MANUAL_ABORT;
   endsequence
   chk_abort_path: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_abort_req |=> (!LOCAL_SYNC && LOG_DISCARD && !LOG_FLUSH)
      ##1 (state_r == ESS_IDLE))
      else $error("Abort sequence wrong");

   chk_halt_ack: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_RUN && psync.fall && !MANUAL_ABORT && !MANUAL_CYCLE)
      |=> (!LOCAL_SYNC && LOG_FLUSH && !CLK_RUNNING && END_TIME == EXP_TIME)
      ##1 (state_r == ESS_IDLE))
      else $error("Halt acknowledge wrong");

   chk_idle_rest: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_IDLE && !USER_START) |=> (state_r == ESS_IDLE && !CLK_RUNNING))
      else $error("Idle left without command");

   chk_error_path: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_INIT && psync.level) |=> (state_r == ESS_ERROR && !LOCAL_SYNC))
      else $error("Early partner run not flagged");

   chk_cycle_end: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (active && MANUAL_CYCLE) |=> !LOCAL_SYNC ##1 !active)
      else $error("Manual cycle did not end sequencing");

   // Outgoing line is a pure level of the sequencing state
   chk_line_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      LOCAL_SYNC == ((state_r == ESS_READY) || (state_r == ESS_RUN)))
      else $error("Outgoing line does not follow state");

   chk_flush_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      LOG_FLUSH |-> (state_r == ESS_HALT_ACK))
      else $error("Log flush outside halt acknowledge");

   chk_discard_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      LOG_DISCARD |-> (state_r == ESS_ABORT))
      else $error("Log discard outside abort");

   chk_error_leave: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_ERROR) |=> (state_r == ESS_IDLE && !LOCAL_SYNC))
      else $error("Error state not left for idle");

   chk_clock_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == ESS_IDLE) |=> $stable(EXP_TIME))
      else $error("Experiment clock moved in idle");
endmodule : ess_top
`default_nettype wire

// ===== src/ess_pkg.sv
// Package of constants and types for the experiment start sync handshake
package ess_pkg;
   localparam int ESS_CLK_MHZ = 250;
   localparam int ESS_CLK_W = 32;
   localparam logic [31:0] ESS_CLK_RESET = 32'h0000_0000;
   localparam logic [31:0] ESS_CLK_INC = 32'h0000_0001;
   localparam int ESS_SYNC_STAGES = 2;

   typedef enum logic [6:0] {
      ESS_INIT = 7'b000_0001,
      ESS_READY = 7'b000_0010,
      ESS_RUN = 7'b000_0100,
      ESS_ABORT = 7'b000_1000,
      ESS_HALT_ACK = 7'b001_0000,
      ESS_IDLE = 7'b010_0000,
      ESS_ERROR = 7'b100_0000
   } ess_state_t;
endpackage : ess_pkg

// ===== src/ess_sync_if.sv
// Interface carrying the synchronised partner line and its edges
`timescale 1ns/100ps
`default_nettype none
interface ess_sync_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : ess_sync_if
`default_nettype wire

// ===== src/ess_line_sync.sv
// Two-stage synchroniser and edge detector for the partner status line
`timescale 1ns/100ps
`default_nettype none
module ess_line_sync
   import ess_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   ess_sync_if.src sync
);
   logic meta_r;
   logic stab_r;
   logic prev_r;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= 1'b0;
         stab_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= async_in;
         stab_r <= meta_r;
         prev_r <= stab_r;
      end
   end

   assign sync.level = stab_r;
   assign sync.rise = stab_r & ~prev_r;
   assign sync.fall = ~stab_r & prev_r;

   chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(stab_r) |-> $past(async_in, 2))
      else $error("Level reached stable stage without two flops");
endmodule : ess_line_sync
`default_nettype wire

// ===== tb/ess_partner_model.sv
// Behavioural model of the processor side of the start handshake
`timescale 1ns/100ps
`default_nettype none
module ess_partner_model
#(
   parameter int SETTLE = 4,
   parameter int RUN_LEN = 20
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Handshake lines
   input wire logic v_sync,
   output logic f_sync,
   // Test controls
   input wire logic early,
   input wire logic restart
);
   logic [2:0] st_r;
   logic [7:0] cnt_r;
   assign f_sync = (st_r == 3'h3);
   // Counts settle then run time
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 8'h00;
      else
         cnt_r <= (st_r == 3'h2 || st_r == 3'h3) ? cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= 3'h0;
      else
         case (st_r)
            3'h0: st_r <= 3'h1;
            3'h1: if (v_sync || early) st_r <= 3'h2;
            3'h2: if (cnt_r == 8'(SETTLE)) st_r <= 3'h3;
            3'h3: if (cnt_r == 8'(SETTLE + RUN_LEN)) st_r <= 3'h4;
            3'h4: if (!v_sync) st_r <= 3'h5;
            default: if (restart) st_r <= 3'h0;
         endcase
   end
endmodule : ess_partner_model
`default_nettype wire

// ===== tb/tb_ess_top.sv
// Testbench for the start handshake simulation side
`timescale 1ns/100ps
`default_nettype none
module tb_ess_top
   import ess_pkg::*;
;
   logic clk, rst_n, p_sync, l_sync, setup, abrt, cyc, start, early, rstrt;
   logic log_act, flush, discard, running;
   logic [31:0] exp_time, end_time;
   logic [6:0] state;
   int fail_count, checked;
   ess_top #(.CLK_W(32)) u_dut (.CORE_CLK(clk), .RST_N(rst_n), .PARTNER_SYNC(p_sync),
      .LOCAL_SYNC(l_sync), .SETUP_DONE(setup), .MANUAL_ABORT(abrt), .MANUAL_CYCLE(cyc),
      .USER_START(start), .LOG_ACTIVE(log_act), .LOG_FLUSH(flush), .LOG_DISCARD(discard),
      .CLK_RUNNING(running), .EXP_TIME(exp_time), .END_TIME(end_time), .STATE(state));
   ess_partner_model u_pm (.clk(clk), .rst_n(rst_n), .v_sync(l_sync), .f_sync(p_sync),
      .early(early), .restart(rstrt));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic wait_st(input logic [6:0] s);
      for (int i = 0; i < 300; i++)
      begin
         @(posedge clk);
         #1;
         if (state === s) return;
      end
      fail_count++;
      $display("FAIL %0t state wait timed out", $time);
      end_sim();
   endtask : wait_st
   // 0 setup, 1 abort, 2 cycle, 3 start, other restart
   task automatic pulse(input int w);
      @(posedge clk);
      case (w)
         0: setup <= 1'b1;
         1: abrt <= 1'b1;
         2: cyc <= 1'b1;
         3: start <= 1'b1;
         default: rstrt <= 1'b1;
      endcase
      @(posedge clk);
      {setup, abrt, cyc, start, rstrt} <= 5'h00;
   endtask : pulse
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic restart_all;
      for (int i = 0; i < 300 && u_pm.st_r !== 3'h5; i++) @(posedge clk);
      check(32'(u_pm.st_r), 32'h5);
      pulse(4);
      pulse(3);
      step();
      check(32'(state), 32'(ESS_INIT));
      check(exp_time, 32'h0);
   endtask : restart_all
   task automatic t_normal;
      logic [31:0] t;
      check(32'({state, l_sync}), 32'({ESS_INIT, 1'b0}));
      pulse(0);
      #1;
      check(32'({state, l_sync, log_act, running}), 32'({ESS_READY, 3'h4}));
      wait_st(ESS_RUN);
      check(32'({l_sync, log_act, running}), 32'h7);
      t = exp_time;
      step();
      check(exp_time, t + 32'h1);
      wait_st(ESS_HALT_ACK);
      check(32'({l_sync, flush, running}), 32'h2);
      t = exp_time;
      step();
      check(32'(state), 32'(ESS_IDLE));
      check(end_time, t);
      check(exp_time, t);
      repeat (5) step();
      check(32'({state, running}), 32'({ESS_IDLE, 1'b0}));
   endtask : t_normal
   task automatic t_abort;
      restart_all();
      pulse(0);
      wait_st(ESS_RUN);
      pulse(1);
      #1;
      check(32'({state, l_sync, discard, running}), 32'({ESS_ABORT, 3'h2}));
      step();
      check(32'({state, log_act}), 32'({ESS_IDLE, 1'b0}));
   endtask : t_abort
   task automatic t_cycle;
      restart_all();
      pulse(0);
      pulse(2);
      #1;
      check(32'({state, l_sync}), 32'({ESS_IDLE, 1'b0}));
   endtask : t_cycle
   task automatic t_error;
      @(posedge clk);
      early <= 1'b1;
      restart_all();
      wait_st(ESS_ERROR);
      check(32'(l_sync), 32'h0);
      step();
      check(32'(state), 32'(ESS_IDLE));
      @(posedge clk);
      early <= 1'b0;
   endtask : t_error
   initial
   begin
      {rst_n, setup, abrt, cyc, start, early, rstrt} = 7'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      step();
      t_normal();
      t_abort();
      t_cycle();
      t_error();
      end_sim();
   end
endmodule : tb_ess_top
`default_nettype wire
